// [logic/ssipos_buf.sv]
`timescale 1ns/10ps
// two-entry buffer with valid and ready on both sides
module ssipos_buf #(
	parameter int WIDTH = ssipos_pkg::WORD_MAX
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_r [ssipos_pkg::BUF_DEPTH];
	logic             wp_r;
	logic             rp_r;
	logic [1:0]       cnt_r;
	wire              push = in_valid_i && (cnt_r != 2'h2);
	wire              pop  = out_ready_i && (cnt_r != 2'h0);

	assign in_ready_o  = (cnt_r != 2'h2);
	assign out_valid_o = (cnt_r != 2'h0);
	assign out_data_o  = mem_r[rp_r];

	// pointers and fill count
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end
		else if (ce_i)
		begin
			if (push)
				wp_r <= ~wp_r;
			if (pop)
				rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// storage
	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
			mem_r[wp_r] <= in_data_i;
	end
endmodule // ssipos_buf

// [logic/ssipos_slave.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module ssipos_slave #(
	parameter int MONO_CYC = ssipos_pkg::MONO_CYC
) (
	input  wire logic                             clk_i,
	input  wire logic                             reset_n_i,
	input  wire logic                             ce_i,
	input  wire logic                             link_clk_i,
	output logic                                  link_data_o,
	input  wire logic                             pos_valid_i,
	output logic                                  pos_ready_o,
	input  wire logic [ssipos_pkg::WORD_MAX-1:0]  pos_data_i,
	input  wire logic [ssipos_pkg::LEN_W-1:0]     word_len_i,
	output logic                                  busy_o,
	output logic      [ssipos_pkg::WORD_MAX-1:0]  last_word_o
);
	////////////////////////////////////////////////////////////////////////
	localparam int W = ssipos_pkg::WORD_MAX;

	ssipos_pkg::ssipos_state_type state_r;
	ssipos_pkg::ssipos_state_type state_nxt;
	logic                         lclk_s;
	logic                         lclk_d_r;
	logic [W-1:0]                 shreg_r;
	logic [W-1:0]                 shreg_nxt;
	logic [W-1:0]                 cur_pos_r;
	logic [ssipos_pkg::LEN_W-1:0] len_r;
	logic [ssipos_pkg::MONO_W-1:0] mono_r;
	logic                         first_r;
	logic [ssipos_pkg::LEN_W-1:0] sent_r;
	logic                         data_nxt;
	logic                         buf_ready;
	logic                         buf_valid;
	logic [W-1:0]                 buf_data;

	////////////////////////////////////////////////////////////////////////
	// link clock sampled, edges found on the system clock
	ssipos_sync #(
		.INIT (1'b1)
	) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.pin_i     (link_clk_i),
		.sync_o    (lclk_s)
	);

	// position source feeds through a two-entry buffer
	ssipos_buf #(
		.WIDTH (W)
	) u_buf (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.ce_i        (ce_i),
		.in_valid_i  (pos_valid_i),
		.in_ready_o  (buf_ready),
		.in_data_i   (pos_data_i),
		.out_valid_o (buf_valid),
		.out_ready_i (1'b1),
		.out_data_o  (buf_data)
	);

	wire fall_edge = lclk_d_r && !lclk_s;
	wire rise_edge = !lclk_d_r && lclk_s;
	wire mono_done = (mono_r == ssipos_pkg::MONO_W'(MONO_CYC - 1));
	// one more rise of the burst, counter saturates
	wire sent_step = (state_r == ssipos_pkg::SSIPOS_SHIFT) && rise_edge
		&& (sent_r != '1);
	wire [ssipos_pkg::LEN_W-1:0] len_min =
		ssipos_pkg::LEN_W'(ssipos_pkg::WORD_MIN);
	// clamp length into the documented span
	wire [ssipos_pkg::LEN_W-1:0] len_ok =
		(word_len_i < len_min) ? len_min :
		(word_len_i > ssipos_pkg::LEN_W'(W)) ? ssipos_pkg::LEN_W'(W) :
		word_len_i;
	// left align the binary word so its MSB sits at the top bit
	wire [W-1:0] aligned = cur_pos_r << (ssipos_pkg::LEN_W'(W) - len_ok);

	////////////////////////////////////////////////////////////////////////
	// state and output decode
	always_comb
	begin
		state_nxt = state_r;
		shreg_nxt = shreg_r;
		data_nxt  = link_data_o;
		case (state_r)
			ssipos_pkg::SSIPOS_IDLE:
			begin
				data_nxt = ssipos_pkg::DATA_IDLE;
				if (fall_edge)             // capture only on master edge
				begin
					shreg_nxt = aligned;     // freeze binary word
					data_nxt  = ssipos_pkg::DATA_BUSY; // busy low
					state_nxt = ssipos_pkg::SSIPOS_SHIFT;
				end
			end
			ssipos_pkg::SSIPOS_SHIFT:
			begin
				if (rise_edge)
				begin
					data_nxt  = shreg_r[W-1];      // MSB first
					shreg_nxt = {shreg_r[W-2:0], 1'b0}; // zero fill
				end
				if (mono_done)
				begin
					data_nxt  = ssipos_pkg::DATA_IDLE; // re-arm
					state_nxt = ssipos_pkg::SSIPOS_IDLE;
				end
			end
			default:
			begin
				data_nxt  = ssipos_pkg::DATA_IDLE;
				state_nxt = ssipos_pkg::SSIPOS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// main registers
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_r     <= ssipos_pkg::SSIPOS_IDLE;
			lclk_d_r    <= 1'b1;
			shreg_r     <= '0;
			link_data_o <= ssipos_pkg::DATA_IDLE;
		end
		else if (ce_i)
		begin
			state_r     <= state_nxt;
			lclk_d_r    <= lclk_s;
			shreg_r     <= shreg_nxt;
			link_data_o <= data_nxt;
		end
	end

	// monoflop counts idle cycles since the last clock edge
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			mono_r <= '0;
		else if (ce_i)
		begin
			if (state_r != ssipos_pkg::SSIPOS_SHIFT || fall_edge || rise_edge)
				mono_r <= '0;
			else if (!mono_done)
				mono_r <= mono_r + 1'b1;
		end
	end

	// rises seen since capture, marks the end of the word
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			sent_r <= '0;
		else if (ce_i)
		begin
			if (state_r == ssipos_pkg::SSIPOS_IDLE && fall_edge)
				sent_r <= '0;
			else if (sent_step)
				sent_r <= sent_r + 1'b1;
		end
	end

	// latest position, taken from the buffer whenever it holds a word
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cur_pos_r   <= '0;
			len_r       <= ssipos_pkg::LEN_W'(ssipos_pkg::WORD_DEF);
			first_r     <= 1'b0;
			pos_ready_o <= 1'b0;
			busy_o      <= 1'b0;
			last_word_o <= '0;
		end
		else if (ce_i)
		begin
			pos_ready_o <= buf_ready;
			busy_o      <= (state_nxt != ssipos_pkg::SSIPOS_IDLE);
			if (buf_valid)
				cur_pos_r <= buf_data; // value passed unaltered
			if (state_r == ssipos_pkg::SSIPOS_IDLE && fall_edge)
			begin
				len_r       <= len_ok;   // length fixed per burst
				last_word_o <= aligned;
				first_r     <= 1'b1;
			end
			else if (rise_edge)
				first_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_capture_drives_low: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_IDLE && fall_edge)
			|=> (!link_data_o && state_r == ssipos_pkg::SSIPOS_SHIFT))
		else $error("capture did not drive data low");

	a_msb_first_bit: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && rise_edge
			&& !mono_done)
			|=> (link_data_o == $past(shreg_r[W-1])))
		else $error("shifted bit is not the top bit");

	a_idle_data_high: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_r == ssipos_pkg::SSIPOS_IDLE && $past(state_r)
			== ssipos_pkg::SSIPOS_IDLE) |-> link_data_o)
		else $error("data not high while idle");

	a_mono_rearm: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && mono_done)
			|=> (state_r == ssipos_pkg::SSIPOS_IDLE && link_data_o))
		else $error("monoflop expiry did not re-arm");

	a_word_frozen: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && !rise_edge
			&& !mono_done) |=> (shreg_r == $past(shreg_r)))
		else $error("shift word changed without a clock edge");

	a_zero_fill: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && rise_edge)
			|=> (shreg_r[0] == 1'b0))
		else $error("extra clocks did not fill with zero");

	a_edge_restarts: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && rise_edge)
			|=> (mono_r == '0))
		else $error("monoflop not restarted by clock activity");

	a_length_span: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(len_r >= len_min && len_r <= ssipos_pkg::LEN_W'(W)))
		else $error("word length out of span");

	a_zero_past_word: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && rise_edge
			&& !mono_done && sent_r >= len_r) |=> !link_data_o)
		else $error("bit past the word is not zero");

	a_bit_order: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_SHIFT && rise_edge
			&& !mono_done && sent_r < len_r)
			|=> (link_data_o == $past(last_word_o[W - 1 - sent_r])))
		else $error("bit order differs from the captured word");

	a_lead_low: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(first_r && state_r == ssipos_pkg::SSIPOS_SHIFT) |-> !link_data_o)
		else $error("data line not low before the first bit");

	a_busy_follows: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(busy_o == (state_r != ssipos_pkg::SSIPOS_IDLE)))
		else $error("busy does not follow the transfer");

	a_word_aligned: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_IDLE && fall_edge)
			|=> ((last_word_o << len_r) == '0))
		else $error("captured word not left aligned");

	a_pos_taken: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && buf_valid)
			|=> (cur_pos_r == $past(buf_data)))
		else $error("position altered on its way in");

	a_no_unasked: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(ce_i && state_r == ssipos_pkg::SSIPOS_IDLE && !fall_edge)
			|=> (state_r == ssipos_pkg::SSIPOS_IDLE && link_data_o))
		else $error("transfer started without a master edge");

	a_mono_bounded: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(mono_r <= ssipos_pkg::MONO_W'(MONO_CYC - 1)))
		else $error("monoflop count past its end");
endmodule // ssipos_slave

// [logic/ssipos_sync.sv]
`timescale 1ns/10ps
// two flip-flop synchroniser for one pin, reset to a chosen level
module ssipos_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	output logic      sync_o
);
	logic meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta_r <= INIT;
			sync_o <= INIT;
		end
		else if (ce_i)
		begin
			meta_r <= pin_i;
			sync_o <= meta_r;
		end
	end
endmodule // ssipos_sync

// [pkg/ssipos_pkg.sv]
package ssipos_pkg;
	// word length limits and default
	localparam int WORD_MAX      = 35;
	localparam int WORD_DEF      = 17;
	localparam int WORD_MIN      = 17;
	localparam int LEN_W         = 6;
	localparam int TURN_BITS     = 16;
	// clock rate and monoflop time
	localparam int CLK_MHZ       = 100;
	localparam int MONO_US       = 16;
	localparam int MONO_CYC      = MONO_US * CLK_MHZ;
	localparam int MONO_W        = 12;
	// idle and busy data line levels
	localparam logic DATA_IDLE   = 1'b1;
	localparam logic DATA_BUSY   = 1'b0;
	// buffer shape
	localparam int BUF_DEPTH     = 2;
	// link states
	typedef enum logic [2:0] {
		SSIPOS_IDLE  = 3'b001,
		SSIPOS_SHIFT = 3'b010,
		SSIPOS_MONO  = 3'b100
	} ssipos_state_type;
endpackage

// [tb/ssipos_master_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// ssi master: makes clock bursts on demand and samples the data line
module ssipos_master_model #(
	parameter int HALF_NS = 80 // shortened bench half period
) (
	input  wire logic link_data_i,
	output logic      link_clk_o
);
	logic        lead_r;
	logic [39:0] rx_r;
	// clock idles high and stands still between bursts
	initial link_clk_o = 1'b1;
	// fall to start, then n rises; sample half a period after the first fall and after each rise
	task automatic burst(input int n);
		begin
			rx_r = 40'h0;
			#7;
			link_clk_o = 1'b0;
			#(HALF_NS);
			lead_r = link_data_i;
			for (int k = 0; k < n; k++)
			begin
				link_clk_o = 1'b1;
				#(HALF_NS);
				rx_r = {rx_r[38:0], link_data_i};
				link_clk_o = (k == n - 1);
				#((k < n - 1) ? HALF_NS : 0);
			end
		end
	endtask
endmodule // ssipos_master_model

// [tb/ssipos_slave_test.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the ssi slave
module ssipos_slave_test;
	localparam int MONO = 40;
	logic                                 clk_i = 1'b0;
	logic                                 reset_n_i = 1'b0;
	logic                                 ce_i = 1'b1;
	logic                                 pos_valid_i = 1'b0;
	logic [ssipos_pkg::WORD_MAX-1:0]      pos_data_i = 35'h0;
	logic [ssipos_pkg::LEN_W-1:0]         word_len_i = 6'h11;
	logic                                 link_clk;
	logic                                 link_data_o;
	logic                                 pos_ready_o;
	logic                                 busy_o;
	logic [ssipos_pkg::WORD_MAX-1:0]      last_word_o;
	int                                   err_count = 0;
	int                                   n_compared = 0;
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	// design and far-side master
	ssipos_slave #(.MONO_CYC(MONO)) ssipos_slave_i (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.link_clk_i(link_clk), .link_data_o(link_data_o),
		.pos_valid_i(pos_valid_i), .pos_ready_o(pos_ready_o),
		.pos_data_i(pos_data_i), .word_len_i(word_len_i),
		.busy_o(busy_o), .last_word_o(last_word_o)
	);
	ssipos_master_model ssipos_master_model_i (
		.link_data_i(link_data_o), .link_clk_o(link_clk)
	);
	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic fail(input string m);
		begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic report_and_stop();
		begin
			$display("compared %0d, mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// hand one position word to the slave, called at a clock edge
	task automatic offer(input logic [34:0] w);
		int k;
		begin
			k = 0;
			pos_valid_i <= 1'b1;
			pos_data_i <= w;
			@(posedge clk_i);
			while (pos_ready_o !== 1'b1 && k < 20)
			begin
				@(posedge clk_i);
				k++;
			end
			if (k == 20)
				fail("no room");
			pos_valid_i <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	// one burst of n + x rises, word p expected left aligned
	task automatic readout(input int n, input int x, input logic [34:0] p);
		begin
			ssipos_master_model_i.burst(n + x);
			n_compared += 4;
			if (ssipos_master_model_i.lead_r !== 1'b0)
				fail("lead level");
			// raw received word compares against p followed by x zero bits
			if (ssipos_master_model_i.rx_r !== 40'(p) << x)
				fail("serial word");
			if (last_word_o !== p << (35 - n))
				fail("captured word");
			if (busy_o !== 1'b1)
				fail("busy dropped");
		end
	endtask
	// wait for the monoflop to expire, then pause before the next burst
	task automatic rearm();
		int c;
		begin
			c = 0;
			while (link_data_o !== 1'b1 && c < 2 * MONO)
			begin
				@(posedge clk_i);
				c++;
			end
			@(posedge clk_i);
			n_compared += 2;
			if (c < MONO - 16 || c > MONO + 8)
				fail("monoflop length");
			if (busy_o !== 1'b0)
				fail("busy after rearm");
			if (c == 2 * MONO)
				report_and_stop();
			repeat (MONO) @(posedge clk_i);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_idle();
		begin
			n_compared += 3;
			if (link_data_o !== 1'b1 || busy_o !== 1'b0 || last_word_o !== 35'h0)
				fail("reset state");
			offer(35'h12345);
			repeat (3 * MONO) @(posedge clk_i);
			if (link_data_o !== 1'b1 || busy_o !== 1'b0)
				fail("sent unasked");
			$display("done idle");
		end
	endtask
	task automatic t_lengths();
		int lens[7] = '{17, 18, 19, 31, 33, 34, 35};
		logic [34:0] p;
		begin
			foreach (lens[i])
			begin
				p = 35'h4B3C2D1E5 & ((35'h1 << lens[i]) - 35'h1);
				word_len_i <= 6'(lens[i]);
				offer(p);
				readout(lens[i], 3, p);
				rearm();
			end
			$display("done lengths");
		end
	endtask
	task automatic t_freeze();
		begin
			word_len_i <= 6'h13;
			offer(35'h5A5A5);
			fork
				readout(19, 1, 35'h5A5A5);
				begin
					repeat (100) @(posedge clk_i);
					offer(35'h3C3C3);
				end
			join
			rearm();
			readout(19, 1, 35'h3C3C3);
			rearm();
			$display("done freeze");
		end
	endtask
	task automatic t_hold();
		begin
			word_len_i <= 6'h11;
			offer(35'h1F0F0);
			readout(17, 1, 35'h1F0F0);
			@(posedge clk_i);
			ce_i <= 1'b0;
			repeat (3 * MONO) @(posedge clk_i);
			n_compared++;
			if (link_data_o !== 1'b0 || busy_o !== 1'b1)
				fail("state moved while held");
			ce_i <= 1'b1;
			rearm();
			$display("done hold");
		end
	endtask
	// lengths outside the span are clamped to the nearest end
	task automatic t_clamp();
		begin
			word_len_i <= 6'h05;
			offer(35'h1ABCD);
			readout(17, 2, 35'h1ABCD);
			rearm();
			word_len_i <= 6'h3F;
			offer(35'h5A5A5A5A5);
			readout(35, 2, 35'h5A5A5A5A5);
			rearm();
			$display("done clamp");
		end
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_idle();
		t_lengths();
		t_freeze();
		t_hold();
		t_clamp();
		report_and_stop();
	end
endmodule // ssipos_slave_test
